// ---- epw_top.sv ----
// Enhanced PWM channel: register set, period timer, outputs and auto shutdown
`timescale 1ns/1ps

module epw_top
  import epw_pkg::*;
#(
  parameter int CHAN_INDEX = 1,               // Instance index only
  parameter int USE_ALT_TIMER = 0,            // 0 timer_period, 1 alt_timer_period
  parameter int ADDR_W = 6,                   // Avalon byte address width
  parameter logic [7:0] DUTY_POR_VAL = 8'h00  // Stands in for the unknown power-on duty
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic por_rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic cmp1_in,
  input wire logic cmp2_in,
  input wire logic ext_interrupt_pin,
  input wire logic [NPIN-1:0] pin_direction_bits,
  output logic out_pin_a_o,
  output logic out_pin_a_oe,
  output logic out_pin_b_o,
  output logic out_pin_b_oe,
  output logic out_pin_c_o,
  output logic out_pin_c_oe,
  output logic out_pin_d_o,
  output logic out_pin_d_oe
);

  // ==========================================================
  // Elaboration checks
  // instance index only
  if (CHAN_INDEX < 0) begin : g_chk_idx
    $error("CHAN_INDEX must not be negative");
  end
  if ((USE_ALT_TIMER != 0) && (USE_ALT_TIMER != 1)) begin : g_chk_alt
    $error("USE_ALT_TIMER must be 0 or 1");
  end
  if (ADDR_W < ADDR_MIN_W) begin : g_chk_addr
    $error("ADDR_W too small for the register map");
  end

  // ==========================================================
  // State of the channel outside the shutdown sync and dead-band blocks
  typedef struct packed {
    logic [REG_W-1:0] tmr_per;     // timer_period
    logic [REG_W-1:0] alt_per;     // alt_timer_period
    logic [REG_W-1:0] duty_lo;     // duty_low, firmware value
    logic [REG_W-1:0] duty_hi;     // duty_high_shadow, active duty upper part
    logic [FINE_W-1:0] duty_lsb;   // Active duty low bits
    logic [REG_W-1:0] ctrl;        // channel_control
    logic [REG_W-1:0] shdn;        // shutdown_control
    logic [REG_W-1:0] del;         // deadband_restart
    logic [INT_W-1:0] int_st;      // Sticky event bits
    logic [INT_W-1:0] int_msk;     // Event mask
    logic [REG_W-1:0] tmr;         // Period timer
    logic [FINE_W-1:0] fine;       // Sub-step below the timer
    logic sd_hold;                 // Shutdown latched at period start
    logic ack;                     // Bus answer cycle
    logic [REG_W-1:0] rdata;       // Captured read data
    logic [NPIN-1:0] pin_o;        // Pin levels
    logic [NPIN-1:0] pin_oe;       // Pin drive enables
  } epw_state_s;

  epw_state_s q_r;
  epw_state_s q_nxt;

  logic rst_any;                   // Any reset source
  logic cause;                     // Selected shutdown cause level
  logic [NPIN/2-1:0] db_level;     // Delayed a and b levels
  logic pwm_raw;                   // Count below duty

  assign rst_any = rst | por_rst;

  // ==========================================================
  // Shutdown source sync and selection
  // source selection
  epw_shutdown u_shutdown (
    .clk(clk),
    .rst(rst_any),
    .src_raw({ext_interrupt_pin, cmp2_in, cmp1_in}),
    .src_sel(q_r.shdn[SHDN_SRC_HI:SHDN_SRC_LO]),
    .cause(cause)
  );

  // ==========================================================
  // Dead-band delay for the primary and complementary outputs
  assign pwm_raw = {q_r.tmr, q_r.fine} < {q_r.duty_hi, q_r.duty_lsb};

  for (genvar gi = 0; gi < NPIN/2; gi++) begin : g_db
    epw_deadband u_db (
      .clk(clk),
      .rst(rst_any),
      .level_in((gi == 0) ? pwm_raw : ~pwm_raw),
      .enable(q_r.ctrl[CTRL_CFG_HI:CTRL_CFG_LO] == CFG_HALF),
      .count(q_r.del[DB_W-1:0]),
      .level_out(db_level[gi])
    );
  end

  // ==========================================================
  // Next-state logic
  logic req;                       // Bus request present
  logic acc;                       // Request completes this edge
  logic wr;                        // Accepted write on lane 0
  logic [ADDR_IDX_W-1:0] sel;      // Word index
  logic [REG_W-1:0] wd;            // Write data byte
  logic [REG_W-1:0] period;        // Selected period value
  logic pwm_on;                    // PWM mode selected
  logic period_start;              // Last sub-step of a period
  logic cause_eff;                 // Cause while PWM runs
  logic st;                        // Shutdown status now
  logic st_nxt;                    // Shutdown status next
  logic fw_set;                    // Firmware forces shutdown
  logic fw_clr;                    // Firmware clears status
  logic auto_clr;                  // Automatic restart clear
  logic sd_now;                    // Outputs in shutdown state
  logic [1:0] cfg;                 // Output configuration
  logic [NPIN-1:0] act;            // Logical active per pin
  logic [NPIN-1:0] drv;            // Pins used by configuration
  logic [1:0] pss;                 // Pair shutdown state
  logic pol;                       // Pair polarity
  logic [INT_W-1:0] ev;            // Events this cycle
  logic [INT_W-1:0] rd_clr;        // Bits cleared by a status read

  always_comb begin
    q_nxt = q_r;
    req = avs_read | avs_write;
    acc = req & q_r.ack;
    sel = avs_address[ADDR_IDX_LO +: ADDR_IDX_W];
    wd = avs_writedata[REG_W-1:0];
    wr = avs_write & acc & avs_byteenable[0];
    cfg = q_r.ctrl[CTRL_CFG_HI:CTRL_CFG_LO];
    act = '0;
    drv = '0;
    pss = '0;
    pol = 1'b0;
    rd_clr = '0;

    // Bus answer: one wait cycle, then the access completes
    q_nxt.ack = req & ~q_r.ack;
    if (req && !q_r.ack && avs_read) begin
      // Capture read data in the wait cycle; it stands at completion
      unique case (sel)
        IDX_TMR_PER: q_nxt.rdata = q_r.tmr_per;
        IDX_ALT_PER: q_nxt.rdata = q_r.alt_per;
        IDX_DUTY_LO: q_nxt.rdata = q_r.duty_lo;
        IDX_DUTY_HI: q_nxt.rdata = q_r.duty_hi;
        IDX_CTRL: q_nxt.rdata = q_r.ctrl;
        IDX_SHDN: q_nxt.rdata = q_r.shdn;
        IDX_DEL: q_nxt.rdata = q_r.del;
        IDX_INT_ST: q_nxt.rdata = {{(REG_W-INT_W){1'b0}}, q_r.int_st};
        IDX_INT_MSK: q_nxt.rdata = {{(REG_W-INT_W){1'b0}}, q_r.int_msk};
        default: q_nxt.rdata = '0;
      endcase
    end

    // Plain register writes
    if (wr) begin
      unique case (sel)
        IDX_TMR_PER: q_nxt.tmr_per = wd;
        IDX_ALT_PER: q_nxt.alt_per = wd;
        IDX_DUTY_LO: q_nxt.duty_lo = wd;
        IDX_CTRL: q_nxt.ctrl = wd;
        IDX_SHDN: q_nxt.shdn[SHDN_SRC_HI:0] = wd[SHDN_SRC_HI:0];
        IDX_DEL: q_nxt.del = wd;
        IDX_INT_MSK: q_nxt.int_msk = wd[INT_W-1:0];
        default: ;
      endcase
    end

    period = (USE_ALT_TIMER == 1) ? q_r.alt_per : q_r.tmr_per;
    pwm_on = q_r.ctrl[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_PWM;
    period_start = pwm_on && (q_r.fine == FINE_MAX) && (q_r.tmr == period);
    if (!pwm_on) begin
      // Idle timer while PWM is off
      q_nxt.tmr = '0;
      q_nxt.fine = '0;
    end else begin
      q_nxt.fine = q_r.fine + {{(FINE_W-1){1'b0}}, 1'b1};
      if (q_r.fine == FINE_MAX) begin
        q_nxt.tmr = (q_r.tmr == period) ? '0 : q_r.tmr + 8'h01;
      end
    end

    if (!pwm_on || period_start) begin
      q_nxt.duty_hi = q_r.duty_lo;
      q_nxt.duty_lsb = q_r.ctrl[CTRL_DLSB_HI:CTRL_DLSB_LO];
    end

    // status set by cause or forced write; set wins
    cause_eff = cause & pwm_on;
    st = q_r.shdn[SHDN_STAT];
    fw_set = wr && (sel == IDX_SHDN) && wd[SHDN_STAT];
    fw_clr = wr && (sel == IDX_SHDN) && !wd[SHDN_STAT] && !cause_eff;
    auto_clr = q_r.del[DEL_RSEN] && st && !cause_eff;
    st_nxt = cause_eff | fw_set | (st & ~(fw_clr | auto_clr));
    q_nxt.shdn[SHDN_STAT] = st_nxt;

    // shutdown held through a period that began in it
    if (!pwm_on) begin
      q_nxt.sd_hold = 1'b0;
    end else if (period_start) begin
      q_nxt.sd_hold = st;
    end
    sd_now = st | q_r.sd_hold;

    unique case (cfg)
      CFG_SINGLE: begin
        act = {3'h0, db_level[0]};
        drv = 4'h1;
      end
      CFG_FULL_FWD: begin
        act = {db_level[0], 2'h0, 1'b1};
        drv = 4'hf;
      end
      CFG_HALF: begin
        act = {2'h0, db_level[1], db_level[0]};
        drv = 4'h3;
      end
      CFG_FULL_REV: begin
        act = {1'b0, 1'b1, db_level[0], 1'b0};
        drv = 4'hf;
      end
    endcase

    // Pin levels and enables; even index is pair A/C, odd is B/D
    for (int i = 0; i < NPIN; i++) begin
      pss = (i % 2 == 0) ? q_r.shdn[SHDN_AC_HI:SHDN_AC_LO] : q_r.shdn[SHDN_BD_HI:SHDN_BD_LO];
      pol = (i % 2 == 0) ? q_r.ctrl[CTRL_POL_AC] : q_r.ctrl[CTRL_POL_BD];
      if (!pwm_on || !drv[i]) begin
        q_nxt.pin_o[i] = 1'b0;
        q_nxt.pin_oe[i] = 1'b0;
      end else if (sd_now) begin
        q_nxt.pin_o[i] = pss[PSS_LVL_BIT] & ~pss[PSS_TRI_BIT];
        q_nxt.pin_oe[i] = ~pss[PSS_TRI_BIT] & ~pin_direction_bits[i];
      end else begin
        // no drive while direction says input
        q_nxt.pin_o[i] = act[i] ^ pol;
        q_nxt.pin_oe[i] = ~pin_direction_bits[i];
      end
    end

    // Sticky events; a read clears only the bits it returned
    ev = '0;
    ev[INT_PERIOD] = period_start;
    ev[INT_SHDN] = st_nxt & ~st;
    if (avs_read && acc && (sel == IDX_INT_ST)) begin
      rd_clr = q_r.rdata[INT_W-1:0];
    end
    q_nxt.int_st = (q_r.int_st & ~rd_clr) | ev;

    // Reset: any reset clears most state; power-on also clears delay and loads duty with DUTY_POR_VAL
    if (rst_any) begin
      q_nxt.tmr_per = PER_RST;
      q_nxt.alt_per = PER_RST;
      // control and shutdown on every reset
      q_nxt.ctrl = CTRL_RST;
      q_nxt.shdn = SHDN_RST;
      q_nxt.int_st = '0;
      q_nxt.int_msk = '0;
      q_nxt.tmr = '0;
      q_nxt.fine = '0;
      q_nxt.sd_hold = 1'b0;
      q_nxt.ack = 1'b0;
      q_nxt.rdata = '0;
      q_nxt.pin_o = '0;
      q_nxt.pin_oe = '0;
      q_nxt.duty_lsb = q_r.duty_lsb;
      if (por_rst) begin
        q_nxt.del = DEL_RST;
        q_nxt.duty_lo = DUTY_POR_VAL;
        q_nxt.duty_hi = DUTY_POR_VAL;
        q_nxt.duty_lsb = '0;
      end else begin
        q_nxt.del = q_r.del;
        q_nxt.duty_lo = q_r.duty_lo;
        q_nxt.duty_hi = q_r.duty_hi;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    q_r <= q_nxt;
  end

  // ==========================================================
  // Outputs
  assign avs_waitrequest = (avs_read | avs_write) & ~q_r.ack;
  assign avs_readdata = {{(DATA_W-REG_W){1'b0}}, q_r.rdata};
  assign irq = |(q_r.int_st & q_r.int_msk);
  assign out_pin_a_o = q_r.pin_o[0];
  assign out_pin_a_oe = q_r.pin_oe[0];
  assign out_pin_b_o = q_r.pin_o[1];
  assign out_pin_b_oe = q_r.pin_oe[1];
  assign out_pin_c_o = q_r.pin_o[2];
  assign out_pin_c_oe = q_r.pin_oe[2];
  assign out_pin_d_o = q_r.pin_o[3];
  assign out_pin_d_oe = q_r.pin_oe[3];

endmodule : epw_top

// ---- epw_pkg.sv ----
// Shared constants for the enhanced PWM channel register set
package epw_pkg;

  // ==========================================================
  // Bus and register geometry
  localparam int DATA_W = 32;          // Avalon data width
  localparam int REG_W = 8;            // Width of the channel registers except interrupt status and mask (INT_W)
  localparam int ADDR_IDX_LO = 2;      // Lowest byte-address bit of the word index
  localparam int ADDR_IDX_W = 4;       // Width of the word index
  localparam int ADDR_MIN_W = ADDR_IDX_LO + ADDR_IDX_W;

  // Word indices; byte address is four times the index
  localparam logic [3:0] IDX_TMR_PER = 4'h0;   // timer_period
  localparam logic [3:0] IDX_ALT_PER = 4'h1;   // alt_timer_period
  localparam logic [3:0] IDX_DUTY_LO = 4'h2;   // duty_low
  localparam logic [3:0] IDX_DUTY_HI = 4'h3;   // duty_high_shadow, read only
  localparam logic [3:0] IDX_CTRL = 4'h4;      // channel_control
  localparam logic [3:0] IDX_SHDN = 4'h5;      // shutdown_control
  localparam logic [3:0] IDX_DEL = 4'h6;       // deadband_restart
  localparam logic [3:0] IDX_INT_ST = 4'h7;    // Interrupt status, cleared by read
  localparam logic [3:0] IDX_INT_MSK = 4'h8;   // Interrupt mask

  // ==========================================================
  // Field positions
  localparam int CTRL_CFG_HI = 7;      // output_config_sel
  localparam int CTRL_CFG_LO = 6;
  localparam int CTRL_DLSB_HI = 5;     // duty_lsb_hi
  localparam int CTRL_DLSB_LO = 4;     // duty_lsb_lo
  localparam int CTRL_MODE_HI = 3;     // mode_polarity_sel group bits
  localparam int CTRL_MODE_LO = 2;
  localparam int CTRL_POL_AC = 1;      // A/C active low when set
  localparam int CTRL_POL_BD = 0;      // B/D active low when set
  localparam int SHDN_STAT = 7;        // shutdown_event_status
  localparam int SHDN_SRC_HI = 6;      // shutdown_source_sel
  localparam int SHDN_SRC_LO = 4;
  localparam int SHDN_AC_HI = 3;       // pair_ac_shutdown_state
  localparam int SHDN_AC_LO = 2;
  localparam int SHDN_BD_HI = 1;       // pair_bd_shutdown_state
  localparam int SHDN_BD_LO = 0;
  localparam int DEL_RSEN = 7;         // auto_restart_enable
  localparam int DB_W = 7;             // deadband_count width
  localparam int PSS_TRI_BIT = 1;      // Pin state: set means tri-state
  localparam int PSS_LVL_BIT = 0;      // Pin state: driven level

  // ==========================================================
  // Reset values
  localparam logic [7:0] PER_RST = 8'hff;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SHDN_RST = 8'h00;
  localparam logic [7:0] DEL_RST = 8'h00;

  // ==========================================================
  // Encodings
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_FULL_FWD = 2'h1;
  localparam logic [1:0] CFG_HALF = 2'h2;
  localparam logic [1:0] CFG_FULL_REV = 2'h3;
  localparam logic [1:0] MODE_PWM = 2'h3;   // Upper mode bits that select PWM
  localparam int SRC_W = 3;                 // Source bits: 0 cmp1, 1 cmp2, 2 ext pin
  localparam int NPIN = 4;                  // Pins a, b, c, d
  localparam int FINE_W = 2;                // Sub-step counter under the timer
  localparam logic [1:0] FINE_MAX = 2'h3;
  localparam int INT_W = 2;
  localparam int INT_PERIOD = 0;            // Period start event
  localparam int INT_SHDN = 1;              // Shutdown event

endpackage : epw_pkg

// ---- epw_shutdown.sv ----
// Shutdown source synchroniser and source selection
`timescale 1ns/1ps

module epw_shutdown
  import epw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [SRC_W-1:0] src_raw,
  input wire logic [SRC_W-1:0] src_sel,
  output logic cause
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [SRC_W-1:0] s1;    // First stage, read only by s2
    logic [SRC_W-1:0] s2;
    logic [SRC_W-1:0] s3;
    logic [SRC_W-1:0] filt;  // Accepted level per source
  } epw_sync_s;

  epw_sync_s q_r;
  epw_sync_s q_nxt;
  logic [SRC_W-1:0] agree;   // Second and third stage match

  // Three-stage sync; a change counts once stages two and three agree
  always_comb begin
    q_nxt = q_r;
    agree = ~(q_r.s2 ^ q_r.s3);
    q_nxt.s1 = src_raw;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    q_nxt.filt = (agree & q_r.s3) | (~agree & q_r.filt);
    if (rst) begin
      q_nxt = '0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    q_r <= q_nxt;
  end

  // Selected sources ORed; code 000 gives no cause
  assign cause = |(q_r.filt & src_sel);

endmodule : epw_shutdown

// ---- epw_deadband.sv ----
// Dead-band delay on the inactive-to-active edge of one output
`timescale 1ns/1ps

module epw_deadband
  import epw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic level_in,
  input wire logic enable,
  input wire logic [DB_W-1:0] count,
  output logic level_out
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [DB_W-1:0] cnt;    // Cycles waited since the active request
    logic out;               // Delayed level
  } epw_db_s;

  epw_db_s q_r;
  epw_db_s q_nxt;

  // Going inactive is immediate; going active waits count cycles
  always_comb begin
    q_nxt = q_r;
    if (!level_in) begin
      // Inactive request clears the wait
      q_nxt.out = 1'b0;
      q_nxt.cnt = '0;
    end else if (!q_r.out) begin
      if (!enable || (q_r.cnt >= count)) begin
        q_nxt.out = 1'b1;
      end else begin
        q_nxt.cnt = q_r.cnt + {{(DB_W-1){1'b0}}, 1'b1};
      end
    end
    if (rst) begin
      q_nxt = '0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    q_r <= q_nxt;
  end

  assign level_out = q_r.out;

endmodule : epw_deadband

// ---- epw_asserts.sv ----
// Port-level checks for the enhanced PWM channel
`timescale 1ns/1ps
module epw_asserts
  import epw_pkg::*;
#(
  parameter int ADDR_W = 6
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic por_rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic [NPIN-1:0] pin_direction_bits,
  input wire logic out_pin_a_oe,
  input wire logic out_pin_b_oe,
  input wire logic out_pin_c_oe,
  input wire logic out_pin_d_oe
);
  // ==========================================================
  // Shadows of what firmware wrote
  logic [7:0] ctrl_sh_r; // Last channel_control written
  logic [1:0] msk_sh_r; // Last int_mask written
  logic wr_done; // A write completes at this edge
  logic [3:0] oe_v; // Enables {d,c,b,a}
  logic pwm_off; // Mode bits do not select PWM
  assign wr_done = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign oe_v = {out_pin_d_oe, out_pin_c_oe, out_pin_b_oe, out_pin_a_oe};
  assign pwm_off = ctrl_sh_r[3:2] != MODE_PWM;
  // Follows completed writes to control and mask
  always_ff @(posedge clk) begin
    if (rst | por_rst) begin
      ctrl_sh_r <= CTRL_RST;
      msk_sh_r <= 2'h0;
    end else if (wr_done && avs_address[5:2] == IDX_CTRL) begin
      ctrl_sh_r <= avs_writedata[7:0];
    end else if (wr_done && avs_address[5:2] == IDX_INT_MSK) begin
      msk_sh_r <= avs_writedata[1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst || por_rst);
  // ==========================================================
  // Bus handshake
  a_wait_first: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
    else $error("no wait state on first request cycle");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait state");
  a_idle_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high with no request");
  a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  // ==========================================================
  // Pins and interrupt
  a_dir_no_drive: assert property (1'b1 |=> (oe_v & $past(pin_direction_bits)) == 4'h0)
    else $error("pin driven while set as input");
  a_pwm_off_quiet: assert property (pwm_off [*3] |-> oe_v == 4'h0)
    else $error("pin driven with PWM off");
  a_single_pins: assert property ((ctrl_sh_r[7:6] == CFG_SINGLE) [*3] |-> oe_v[3:1] == 3'h0)
    else $error("unused pin driven in single output");
  a_irq_masked: assert property ((msk_sh_r == 2'h0) [*2] |-> !irq)
    else $error("interrupt raised while fully masked");
  a_reset_quiet: assert property (disable iff (por_rst) rst |=> oe_v == 4'h0 && !irq)
    else $error("outputs active after reset");
endmodule : epw_asserts

// ---- epw_bridge_model.sv ----
// Power bridge driver model: pin wires and fault sense lines
`timescale 1ns/1ps
module epw_bridge_model (
  input wire logic clk,
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe,
  input wire logic [2:0] fault_req,
  output logic [3:0] gate_lvl,
  output logic cmp1_in = 1'b0,
  output logic cmp2_in = 1'b0,
  output logic ext_pin = 1'b0
);
  // Released pins fall to the pull-down, so the switches stay off
  assign gate_lvl = pin_o & pin_oe;
  // Fault senses {ext, cmp2, cmp1} change just after an edge
  always @(posedge clk) begin
    {ext_pin, cmp2_in, cmp1_in} <= fault_req;
  end
endmodule : epw_bridge_model

// ---- testbench.sv ----
// Self-checking bench for the enhanced PWM channel
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic por_rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq, cmp1_in, cmp2_in, ext_interrupt_pin;
  logic [3:0] pin_direction_bits = 4'hf; // All pins input at start
  logic out_pin_a_o, out_pin_a_oe, out_pin_b_o, out_pin_b_oe;
  logic out_pin_c_o, out_pin_c_oe, out_pin_d_o, out_pin_d_oe;
  logic [3:0] gate_lvl; // Levels seen by the bridge
  logic [2:0] fault_req = 3'h0; // Requested faults {ext, cmp2, cmp1}
  int fail_count = 0;
  int checks_done = 0;
  // Reset values by word index, last one unmapped
  localparam logic [7:0] RST_V [10] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Output setups: control, delay, expected enables, high counts {d,c,b,a}
  localparam logic [7:0] CFG_CTRL [7] = '{8'h2c, 8'h6c, 8'hac, 8'hec, 8'h2e, 8'haf, 8'hac};
  localparam logic [7:0] CFG_DEL [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
  localparam logic [3:0] CFG_OE [7] = '{4'h1, 4'hf, 4'h3, 4'hf, 4'h1, 4'h3, 4'h3};
  localparam logic [19:0] CFG_CNT [7] = '{20'h00006, 20'h30010, 20'h00146, 20'h040c0, 20'h0000a, 20'h000ca, 20'h00104};
  epw_top epw_top_i (.*);
  epw_bridge_model epw_bridge_model_i (.clk(clk), .pin_o({out_pin_d_o, out_pin_c_o, out_pin_b_o, out_pin_a_o}),
    .pin_oe({out_pin_d_oe, out_pin_c_oe, out_pin_b_oe, out_pin_a_oe}), .fault_req(fault_req),
    .gate_lvl(gate_lvl), .cmp1_in(cmp1_in), .cmp2_in(cmp2_in), .ext_pin(ext_interrupt_pin));
  // 50 MHz clock
  always #10 clk = ~clk;
  // ==========================================================
  // Shared tasks
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One bus transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [5:0] a, input logic [7:0] d, input logic [3:0] be, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= ~w;
    // Waitrequest and read data are judged at the rising edge itself
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task wr(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'h1, q);
  endtask : wr
  task rc(input string nm, input logic [5:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, 4'h1, q);
    chk(nm, q, {24'h0, e});
  endtask : rc
  // Settle, then count bridge levels and enables over one 16-clock period
  task meas(input logic [3:0] eoe, input logic [19:0] ecnt);
    logic [19:0] c;
    logic [3:0] m;
    c = '0;
    m = '0;
    repeat (40) @(posedge clk);
    repeat (16) begin
      @(negedge clk);
      m |= {out_pin_d_oe, out_pin_c_oe, out_pin_b_oe, out_pin_a_oe};
      for (int i = 0; i < 4; i++) c[i*5+:5] += 5'(gate_lvl[i]);
    end
    // Return on a rising edge so callers drive inputs there
    @(posedge clk);
    chk("pin enables", {28'h0, m}, {28'h0, eoe});
    chk("pin high counts", {12'h0, c}, {12'h0, ecnt});
  endtask : meas
  // ==========================================================
  // Scenarios
  task t_configs;
    wr(6'h00, 8'h03); // Period of 16 clocks
    wr(6'h08, 8'h01); // Duty 6 clocks with lsbs 10
    for (int i = 0; i < 7; i++) begin
      pin_direction_bits <= 4'hf;
      wr(6'h18, CFG_DEL[i]);
      wr(6'h10, CFG_CTRL[i]);
      pin_direction_bits <= 4'h0;
      meas(CFG_OE[i], CFG_CNT[i]);
    end
  endtask : t_configs
  task t_shutdown;
    logic [31:0] q;
    wr(6'h18, 8'h00);
    wr(6'h20, 8'h02);
    wr(6'h14, 8'h16); // Cmp1 source, A/C high, B/D tri-state
    fault_req <= 3'h1;
    repeat (20) @(posedge clk);
    rc("shutdown status", 6'h14, 8'h96);
    chk("irq on event", {31'h0, irq}, 32'h1);
    chk("pin a held high", {30'h0, out_pin_a_oe, gate_lvl[0]}, 32'h3);
    chk("pin b released", {31'h0, out_pin_b_oe}, 32'h0);
    wr(6'h14, 8'h16);
    rc("status kept", 6'h14, 8'h96);
    bus(1'b0, 6'h1c, 8'h00, 4'h1, q);
    chk("event flag", {31'h0, q[1]}, 32'h1);
    // Next rising edge sees the state left by the clearing read
    @(posedge clk);
    chk("irq after read", {31'h0, irq}, 32'h0);
    fault_req <= 3'h0;
    repeat (20) @(posedge clk);
    rc("no self clear", 6'h14, 8'h96);
    wr(6'h14, 8'h16);
    rc("firmware clear", 6'h14, 8'h16);
    meas(4'h3, 20'h00146);
    wr(6'h14, 8'h80);
    repeat (3) @(negedge clk);
    chk("forced pins", {28'h0, out_pin_b_oe, gate_lvl[1], out_pin_a_oe, gate_lvl[0]}, 32'ha);
    rc("forced status", 6'h14, 8'h80);
    wr(6'h14, 8'h00);
    wr(6'h18, 8'h80);
    for (int s = 1; s < 8; s++) begin
      for (int k = 0; k < 3; k++) begin
        wr(6'h14, {1'b0, 3'(s), 4'h6});
        fault_req <= 3'(1 << k);
        repeat (20) @(posedge clk);
        rc("source select", 6'h14, {s[k], 3'(s), 4'h6});
        fault_req <= 3'h0;
        repeat (20) @(posedge clk);
        rc("auto restart", 6'h14, {1'b0, 3'(s), 4'h6});
      end
    end
  endtask : t_shutdown
  task t_keep;
    logic [31:0] q;
    wr(6'h18, 8'h85);
    bus(1'b1, 6'h18, 8'h11, 4'h0, q);
    wr(6'h08, 8'h5a);
    wr(6'h0c, 8'h77);
    wr(6'h24, 8'h11);
    wr(6'h14, 8'h03);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rc("control after reset", 6'h10, 8'h00);
    rc("shutdown after reset", 6'h14, 8'h00);
    rc("delay kept", 6'h18, 8'h85);
    rc("duty kept", 6'h08, 8'h5a);
    rc("duty shadow kept", 6'h0c, 8'h5a);
    rc("unmapped", 6'h24, 8'h00);
  endtask : t_keep
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  // Main sequence after power-on reset
  initial begin
    repeat (3) @(posedge clk);
    por_rst <= 1'b0;
    for (int i = 0; i < 10; i++) rc("reset value", 6'(i * 4), RST_V[i]);
    t_configs();
    t_shutdown();
    t_keep();
    finish_test();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test();
  end
endmodule : testbench
bind epw_top epw_asserts #(.ADDR_W(ADDR_W)) epw_asserts_i (.*);
